// ===== logic/lvd_regs.sv
// control/status register bank for two analog level detectors
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - detectors run free of the bus clock; their outputs are synchronised to the bus clock.
// - only system reset restores defaults; no local software reset.
// - control/status register at offset 0x1C, reads zero after reset.
// - each control field is read/write, or read-only once frozen.
// - bit 0 turns the first detector on.
// - bit 1 closes the switch to the DAC-shared pin when 1.
// - bits 3:2 choose speed and power, 00 fastest, 11 slowest.
// - bits 6:4 choose the negative input source, codes 000 to 101.
// - each detector has an output polarity flip bit.
// - window mode joins positive inputs and cuts the second detector's pin.
// - detector output can reach timer break, clear, capture inputs and a pin.
// - each detector output drives an event controller line.
// - bits 10:8 route the first output; 000 routes nowhere.
// - bit 11 inverts the first output when 1.
// - bit 15 freezes the first detector's controls until system reset.
module lvd_regs
    import lvd_pkg::*;
(
    input  wire logic              i_clk,          // bus clock, 200 MHz
    input  wire logic              i_rst_n,        // system reset, async, active low
    input  wire logic [ADDR_W-1:0] i_addr,         // byte address
    input  wire logic [31:0]       i_wdata,        // write data
    input  wire logic              i_wr,           // write strobe
    input  wire logic              i_rd,           // read strobe
    input  wire logic [DET_N-1:0]  i_raw,          // raw analog detector outputs
    output logic      [31:0]       o_rdata,        // read data, cycle after i_rd
    output logic      [DET_N-1:0]  o_on,           // detector enables
    output logic      [DET_N-1:0]  o_dac_switch,   // dac pin input switch closed
    output logic      [2*DET_N-1:0] o_speed,       // speed/power select, 2 bits each
    output logic      [3*DET_N-1:0] o_neg_sel,     // negative input select, 3 bits each
    output logic      [2*DET_N-1:0] o_hyst,        // hysteresis level, 2 bits each
    output logic      [3*DET_N-1:0] o_route,       // output route select, 3 bits each
    output logic      [DET_N-1:0]  o_level,        // polarity-corrected outputs to pin
    output logic      [DET_N-1:0]  o_event,        // event controller lines
    output logic      [ROUTE_N*DET_N-1:0] o_timer, // timer input lines, one per nonzero route code
    output logic                   o_window,       // positive inputs joined
    output logic                   o_pin2_connect, // second detector own pin connected
    output logic                   o_irq           // interrupt, level
);
    typedef struct packed {
        logic [DET_N-1:0][FIELD_W-1:0] ctl;
        logic                          win;
        logic [DET_N-1:0]              lvl;
        logic [EVT_N-1:0]              sts;
        logic [EVT_N-1:0]              ien;
        logic [31:0]                   rdata;
        logic [ROUTE_N*DET_N-1:0]      timer;
        logic                          irq;
    } lvd_state_t;

    lvd_state_t       st;
    lvd_state_t       next_st;
    logic [DET_N-1:0] sync_raw;
    logic [DET_N-1:0] lvl_now;
    logic [EVT_N-1:0] evt;
    logic [31:0]      csr_view;

    // analog outputs are asynchronous to the bus clock
    lvd_sync #(
        .W (DET_N)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     (i_raw),
        .o_q     (sync_raw)
    );

    always_comb
    begin
        next_st = st;
        for (int d = 0; d < DET_N; d++)
        begin
            lvl_now[d] = sync_raw[d] ^ st.ctl[d][B_FLIP];
            evt[2*d]   = lvl_now[d] & ~st.lvl[d];
            evt[2*d+1] = ~lvl_now[d] & st.lvl[d];
        end
        next_st.lvl = lvl_now;
        csr_view = st.ctl;
        for (int d = 0; d < DET_N; d++)
            csr_view[d*FIELD_W+B_LEVEL] = st.lvl[d];
        if (i_wr && i_addr == OFS_CSR)
        begin
            for (int d = 0; d < DET_N; d++)
            begin
                if (!st.ctl[d][B_FREEZE])
                begin
                    next_st.ctl[d] = i_wdata[d*FIELD_W +: FIELD_W] & WR_MASK;
                    next_st.ctl[d][B_FREEZE] = i_wdata[d*FIELD_W+B_FREEZE];
                end
            end
        end
        if (i_wr && i_addr == OFS_IEN)
            next_st.ien = i_wdata[EVT_N-1:0];
        if (i_wr && i_addr == OFS_WIN)
            next_st.win = i_wdata[0];
        // set wins over a clear in the same cycle
        next_st.sts = st.sts;
        if (i_wr && i_addr == OFS_CLR)
            next_st.sts = st.sts & ~i_wdata[EVT_N-1:0];
        next_st.sts = next_st.sts | evt;
        next_st.irq = |(next_st.sts & next_st.ien);
        for (int d = 0; d < DET_N; d++)
            for (int k = 1; k <= ROUTE_N; k++)
                next_st.timer[d*ROUTE_N+k-1] =
                    (st.ctl[d][B_ROUTE +: ROUTE_W] == ROUTE_W'(k)) && lvl_now[d];
        next_st.rdata = '0;
        if (i_rd)
        begin
            unique case (i_addr)
                OFS_CSR: next_st.rdata = csr_view;
                OFS_STS: next_st.rdata = {{(32-EVT_N){1'b0}}, st.sts};
                OFS_IEN: next_st.rdata = {{(32-EVT_N){1'b0}}, st.ien};
                OFS_WIN: next_st.rdata = {31'h0000_0000, st.win};
                default: next_st.rdata = '0;
            endcase
        end
    end

    // only the system reset clears the bank, freeze bits included
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st     <= '0;
            st.ctl <= CSR_RESET;
        end
        else
            st <= next_st;
    end

    always_comb
    begin
        o_rdata        = st.rdata;
        o_window       = st.win;
        o_pin2_connect = ~st.win;
        o_level        = st.lvl;
        o_event        = st.lvl;
        o_timer        = st.timer;
        o_irq          = st.irq;
        for (int d = 0; d < DET_N; d++)
        begin
            o_on[d]           = st.ctl[d][B_ON];
            o_dac_switch[d]   = st.ctl[d][B_SW];
            o_speed[2*d +: 2] = st.ctl[d][B_SPD +: 2];
            o_neg_sel[3*d +: 3] = st.ctl[d][B_NEG +: 3];
            o_hyst[2*d +: 2]  = st.ctl[d][B_HYS +: 2];
            o_route[3*d +: 3] = st.ctl[d][B_ROUTE +: ROUTE_W];
        end
    end

    freeze_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st.ctl[0][B_FREEZE] |=> st.ctl[0] == $past(st.ctl[0]))
        else $error("frozen first detector field changed");

    freeze_hold2_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st.ctl[1][B_FREEZE] |=> st.ctl[1] == $past(st.ctl[1]))
        else $error("frozen second detector field changed");

    csr_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[0][B_FREEZE])
        |=> o_on[0] == $past(i_wdata[B_ON]) && o_dac_switch[0] == $past(i_wdata[B_SW]))
        else $error("first detector enable or switch not taken from write");

    level_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == OFS_CSR) |=> o_rdata[B_LEVEL] == $past(st.lvl[0]))
        else $error("output level bit reads wrong");

    polarity_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ##1 o_level[0] == ($past(sync_raw[0]) ^ $past(st.ctl[0][B_FLIP])))
        else $error("output polarity not applied");

    route_none_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.ctl[0][B_ROUTE +: ROUTE_W] == '0) |=> o_timer[ROUTE_N-1:0] == '0)
        else $error("timer line active with route off");

    window_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_window |-> !o_pin2_connect)
        else $error("second pin connected in window mode");

    irq_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ##1 o_irq == |($past(next_st.sts) & $past(next_st.ien)))
        else $error("interrupt does not follow enabled status");

    set_wins_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (|evt) |=> (st.sts & $past(evt)) == $past(evt))
        else $error("event lost against clear");

    unmapped_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == OFS_CLR) |=> o_rdata == '0)
        else $error("write-only clear register reads nonzero");

    speed_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[0][B_FREEZE]) |=> o_speed[1:0] == $past(i_wdata[B_SPD +: 2]))
        else $error("first speed select not taken from write");

    neg_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[0][B_FREEZE]) |=> o_neg_sel[2:0] == $past(i_wdata[B_NEG +: 3]))
        else $error("first negative input select not taken from write");

    route_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[0][B_FREEZE])
        |=> o_route[2:0] == $past(i_wdata[B_ROUTE +: ROUTE_W]))
        else $error("first route select not taken from write");

    hyst_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[0][B_FREEZE]) |=> o_hyst[1:0] == $past(i_wdata[B_HYS +: 2]))
        else $error("first hysteresis not taken from write");

    flip_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[0][B_FREEZE]) |=> st.ctl[0][B_FLIP] == $past(i_wdata[B_FLIP]))
        else $error("first polarity bit not taken from write");

    freeze_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[0][B_FREEZE])
        |=> st.ctl[0][B_FREEZE] == $past(i_wdata[B_FREEZE]))
        else $error("first freeze bit not taken from write");

    on2_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[1][B_FREEZE]) |=> o_on[1] == $past(i_wdata[FIELD_W+B_ON]))
        else $error("second enable not taken from write");

    sw2_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[1][B_FREEZE]) |=> o_dac_switch[1] == $past(i_wdata[FIELD_W+B_SW]))
        else $error("second switch not taken from write");

    speed2_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[1][B_FREEZE])
        |=> o_speed[3:2] == $past(i_wdata[FIELD_W+B_SPD +: 2]))
        else $error("second speed select not taken from write");

    neg2_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[1][B_FREEZE])
        |=> o_neg_sel[5:3] == $past(i_wdata[FIELD_W+B_NEG +: 3]))
        else $error("second negative input select not taken from write");

    route2_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[1][B_FREEZE])
        |=> o_route[5:3] == $past(i_wdata[FIELD_W+B_ROUTE +: ROUTE_W]))
        else $error("second route select not taken from write");

    hyst2_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[1][B_FREEZE])
        |=> o_hyst[3:2] == $past(i_wdata[FIELD_W+B_HYS +: 2]))
        else $error("second hysteresis not taken from write");

    flip2_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[1][B_FREEZE])
        |=> st.ctl[1][B_FLIP] == $past(i_wdata[FIELD_W+B_FLIP]))
        else $error("second polarity bit not taken from write");

    freeze2_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CSR && !st.ctl[1][B_FREEZE])
        |=> st.ctl[1][B_FREEZE] == $past(i_wdata[FIELD_W+B_FREEZE]))
        else $error("second freeze bit not taken from write");

    reserved_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.ctl[0] & ~(WR_MASK | (FIELD_W'(1) << B_FREEZE))) == '0)
        else $error("unwritable first field bit stored");

    reserved2_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.ctl[1] & ~(WR_MASK | (FIELD_W'(1) << B_FREEZE))) == '0)
        else $error("unwritable second field bit stored");

    rdata_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_rd |=> o_rdata == '0)
        else $error("read data not zero outside a read");

    sts_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == OFS_STS) |=> o_rdata == 32'($past(st.sts)))
        else $error("status read wrong");

    ien_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == OFS_IEN) |=> o_rdata == 32'($past(st.ien)))
        else $error("enable read wrong");

    win_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == OFS_WIN) |=> o_rdata == 32'($past(st.win)))
        else $error("window mode read wrong");

    ctl_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == OFS_CSR) |=> (o_rdata[FIELD_W-1:0] & WR_MASK) == ($past(st.ctl[0]) & WR_MASK))
        else $error("first control field reads wrong");

    ctl2_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == OFS_CSR)
        |=> (o_rdata[2*FIELD_W-1:FIELD_W] & WR_MASK) == ($past(st.ctl[1]) & WR_MASK))
        else $error("second control field reads wrong");

    level2_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == OFS_CSR) |=> o_rdata[FIELD_W+B_LEVEL] == $past(st.lvl[1]))
        else $error("second output level bit reads wrong");

    win_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_WIN) |=> o_window == $past(i_wdata[0]))
        else $error("window mode not taken from write");

    ien_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_IEN) |=> st.ien == $past(i_wdata[EVT_N-1:0]))
        else $error("enable not taken from write");

    sts_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == OFS_CLR && evt == '0) |=> (st.sts & $past(i_wdata[EVT_N-1:0])) == '0)
        else $error("status not cleared by write");

    sts_sticky_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(i_wr && i_addr == OFS_CLR) |=> (st.sts & $past(st.sts)) == $past(st.sts))
        else $error("status bit dropped without clear");

    rise0_evt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (lvl_now[0] && !st.lvl[0]) |=> st.sts[0])
        else $error("first rise not recorded");

    fall0_evt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!lvl_now[0] && st.lvl[0]) |=> st.sts[1])
        else $error("first fall not recorded");

    rise1_evt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (lvl_now[1] && !st.lvl[1]) |=> st.sts[2])
        else $error("second rise not recorded");

    fall1_evt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!lvl_now[1] && st.lvl[1]) |=> st.sts[3])
        else $error("second fall not recorded");

    event_line_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ##1 o_event == $past(lvl_now))
        else $error("event lines do not follow corrected level");

    route2_none_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.ctl[1][B_ROUTE +: ROUTE_W] == '0) |=> o_timer[2*ROUTE_N-1:ROUTE_N] == '0)
        else $error("second timer line active with route off");

    timer_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $onehot0(o_timer[ROUTE_N-1:0]))
        else $error("first output on several timer lines");

    timer2_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $onehot0(o_timer[2*ROUTE_N-1:ROUTE_N]))
        else $error("second output on several timer lines");

    timer_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (|o_timer[ROUTE_N-1:0]) |-> o_level[0])
        else $error("first timer line high with output low");

    timer2_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (|o_timer[2*ROUTE_N-1:ROUTE_N]) |-> o_level[1])
        else $error("second timer line high with output low");

    polarity2_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ##1 o_level[1] == ($past(sync_raw[1]) ^ $past(st.ctl[1][B_FLIP])))
        else $error("second output polarity not applied");

    irq_now_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_irq == |(st.sts & st.ien))
        else $error("interrupt differs from enabled status");

    ctl_stable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(i_wr && i_addr == OFS_CSR) |=> st.ctl == $past(st.ctl))
        else $error("control changed without a write");

    win_stable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(i_wr && i_addr == OFS_WIN) |=> $stable(o_window))
        else $error("window mode changed without a write");

    ien_stable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(i_wr && i_addr == OFS_IEN) |=> $stable(st.ien))
        else $error("enable changed without a write");
endmodule : lvd_regs
`default_nettype wire

// ===== logic/lvd_pkg.sv
// shared constants for the level detector control block
package lvd_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CSR   = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_STS   = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_CLR   = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_IEN   = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_WIN   = 8'h2C;
    localparam logic [31:0] CSR_RESET = 32'h0000_0000;
    localparam int DET_N     = 2;
    localparam int FIELD_W   = 16;
    localparam int B_ON      = 0;
    localparam int B_SW      = 1;
    localparam int B_SPD     = 2;
    localparam int B_NEG     = 4;
    localparam int B_ROUTE   = 8;
    localparam int B_FLIP    = 11;
    localparam int B_HYS     = 12;
    localparam int B_LEVEL   = 14;
    localparam int B_FREEZE  = 15;
    localparam int ROUTE_W   = 3;
    localparam int ROUTE_N   = 7;
    localparam int EVT_N     = 2 * DET_N;
    // writable control bits of one detector field: 13:8 and 6:0
    localparam logic [FIELD_W-1:0] WR_MASK = 16'h3F7F;
endpackage : lvd_pkg

// ===== logic/lvd_sync.sv
// two-flop synchroniser for asynchronous detector outputs
`timescale 1ns/1ps
`default_nettype none
module lvd_sync #(
    parameter int W = 2
) (
    input  wire logic         i_clk,   // bus clock
    input  wire logic         i_rst_n, // async reset, active low
    input  wire logic [W-1:0] i_d,     // asynchronous levels
    output logic      [W-1:0] o_q      // synchronised levels
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } lvd_sync_t;

    lvd_sync_t st;
    lvd_sync_t next_st;

    always_comb
    begin
        next_st.meta = i_d;
        next_st.q    = st.meta;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign o_q = st.q;
endmodule : lvd_sync
`default_nettype wire

// ===== tb/lvd_raw_model.sv
// behavioural model of the two analog detector cores feeding the register bank
`timescale 1ns/1ps
`default_nettype none
module lvd_raw_model
    import lvd_pkg::*;
(
    input  wire logic [DET_N-1:0] i_on,    // core enables from the bank
    input  wire logic [DET_N-1:0] i_above, // positive input above negative input
    output logic      [DET_N-1:0] o_raw    // raw core outputs, no clock involved
);
    // a disabled core holds its output low; changes are asynchronous to the bus clock
    assign o_raw = i_on & i_above;
endmodule : lvd_raw_model
`default_nettype wire

// ===== tb/test_lvd_regs.sv
// self-checking bench for the level detector control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module test_lvd_regs;
    import lvd_pkg::*;
    logic                     i_clk, i_rst_n, i_wr, i_rd;
    logic [ADDR_W-1:0]        i_addr;
    logic [31:0]              i_wdata, o_rdata;
    logic [DET_N-1:0]         i_raw, above, o_on, o_dac_switch, o_level, o_event;
    logic [2*DET_N-1:0]       o_speed, o_hyst;
    logic [3*DET_N-1:0]       o_neg_sel, o_route;
    logic [ROUTE_N*DET_N-1:0] o_timer;
    logic                     o_window, o_pin2_connect, o_irq;
    int                       error_cnt = 0;
    int                       samples_checked = 0;
    lvd_regs lvd_regs_i (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .i_raw, .o_rdata, .o_on,
        .o_dac_switch, .o_speed, .o_neg_sel, .o_hyst, .o_route, .o_level, .o_event, .o_timer, .o_window,
        .o_pin2_connect, .o_irq);
    lvd_raw_model lvd_raw_model_i (.i_on(o_on), .i_above(above), .o_raw(i_raw));
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= v;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, e);
    endtask : rd
    task automatic settle();
        repeat (4) @(posedge i_clk);
        #1;
    endtask : settle
    task automatic do_reset();
        i_rst_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
    endtask : do_reset
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    initial
    begin
        #20000;
        error_cnt++;
        summarize();
    end
    initial
    begin
        {i_wr, i_rd, i_addr, i_wdata, above} = '0;
        i_rst_n = 1'b0;
        do_reset();
        rd(OFS_CSR, 32'h0000_0000);
        `CHK(o_pin2_connect, 1'b1);
        // every writable field of both halves except freeze bit 15; bit 7 and 14 stay unwritable
        wr(OFS_CSR, 32'h7FFF_7FFF);
        settle();
        rd(OFS_CSR, 32'h7F7F_7F7F);
        `CHK({o_on, o_dac_switch, o_speed, o_neg_sel, o_route, o_hyst}, 24'hFF_FFFF);
        `CHK({o_level, o_event, o_timer}, 18'h3_E040);
        for (int k = 0; k < 8; k++)
        begin
            wr(OFS_CSR, 32'h0801 | (k << 8) | ((k % 4) << 2) | ((k % 6) << 4));
            `CHK(o_route[2:0], k);
            `CHK(o_speed[1:0], k % 4);
            `CHK(o_neg_sel[2:0], k % 6);
            // timer lines are registered one edge after the route field
            @(posedge i_clk);
            #1;
            `CHK(o_timer, (k == 0) ? 0 : (1 << (k - 1)));
        end
        settle();
        // rise of the first detector enabled, its fall masked
        wr(OFS_IEN, 32'h1);
        wr(OFS_CLR, 32'hF);
        wr(OFS_CSR, 32'h0000_0001);
        settle();
        rd(OFS_STS, 32'h2);
        `CHK(o_irq, 1'b0);
        above <= 2'b01;
        settle();
        rd(OFS_STS, 32'h3);
        rd(OFS_CSR, 32'h0000_4001);
        `CHK(o_irq, 1'b1);
        wr(OFS_CLR, 32'h1);
        rd(OFS_STS, 32'h2);
        `CHK(o_irq, 1'b0);
        wr(OFS_WIN, 32'h1);
        `CHK({o_window, o_pin2_connect}, 2'b10);
        rd(OFS_WIN, 32'h1);
        rd(8'h40, 32'h0);
        rd(OFS_CLR, 32'h0);
        // freeze the first half; later writes to it are ignored, second half stays open
        wr(OFS_CSR, 32'h0000_8005);
        wr(OFS_CSR, 32'h0001_0000);
        settle();
        rd(OFS_CSR, 32'h0001_C005);
        `CHK(o_speed[1:0], 2'b01);
        do_reset();
        rd(OFS_CSR, 32'h0000_0000);
        wr(OFS_CSR, 32'h0000_0001);
        `CHK(o_on, 2'b01);
        summarize();
    end
endmodule : test_lvd_regs
`default_nettype wire
